// ### hdl/scg_pkg.sv
// package: register map, field layout and types of the sleep clock gate block
package scg_pkg;

	// ------------------------------------------------------------------
	// register map (byte offsets from the system control base)
	// ------------------------------------------------------------------
	localparam logic [31:0] SCG_SYSCTL_BASE   = 32'h400fe000;
	localparam logic [11:0] SCG_OFF_RUN       = 12'h104;
	localparam logic [11:0] SCG_OFF_SLEEP     = 12'h114;
	localparam logic [11:0] SCG_OFF_DEEP      = 12'h124;
	localparam logic [11:0] SCG_OFF_CONFIG    = 12'h200;
	localparam logic [11:0] SCG_OFF_IRQ_STAT  = 12'h204;
	localparam logic [11:0] SCG_OFF_IRQ_MASK  = 12'h208;
	localparam logic [11:0] SCG_OFF_PMODE     = 12'h20c;

	// ------------------------------------------------------------------
	// gate register fields
	// ------------------------------------------------------------------
	localparam int SCG_BIT_ASER0  = 0;
	localparam int SCG_BIT_ASER1  = 1;
	localparam int SCG_BIT_SSER0  = 4;
	localparam int SCG_BIT_TWI0   = 12;
	localparam int SCG_BIT_TMR0   = 16;
	localparam int SCG_BIT_TMR1   = 17;
	localparam int SCG_BIT_TMR2   = 18;
	localparam int SCG_BIT_CMP0   = 24;
	localparam int SCG_NUM_UNITS  = 8;

	localparam logic [31:0] SCG_GATE_MASK  = 32'h01071013;
	localparam logic [31:0] SCG_GATE_RESET = 32'h00000000;
	localparam logic [31:0] SCG_ZERO_WORD  = 32'h00000000;

	// config register: bit 0 is the auto gate select
	localparam int          SCG_BIT_AUTO_SEL  = 0;
	localparam logic [31:0] SCG_CONFIG_RESET  = 32'h00000000;
	// interrupt status/mask: bit 0 fault, bit 1 gate change
	localparam int          SCG_IRQ_FAULT     = 0;
	localparam int          SCG_IRQ_CHANGE    = 1;
	localparam logic [1:0]  SCG_IRQ_RESET     = 2'h0;

	// ------------------------------------------------------------------
	// types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		SCG_MODE_RUN,
		SCG_MODE_SLEEP,
		SCG_MODE_DEEP
	} scg_mode_t;

	typedef struct packed {
		logic        sel;
		logic        wr;
		logic        en;
		logic [11:0] addr;
		logic [31:0] wdata;
	} scg_req_t;

	typedef struct packed {
		logic [SCG_NUM_UNITS-1:0] sel;
		logic                     en;
	} scg_unit_req_t;

	// expand the 32-bit gate layout to one enable per unit
	function automatic logic [SCG_NUM_UNITS-1:0] scg_units(
		input logic [31:0] w);
		scg_units = {w[SCG_BIT_CMP0], w[SCG_BIT_TMR2], w[SCG_BIT_TMR1],
			w[SCG_BIT_TMR0], w[SCG_BIT_TWI0], w[SCG_BIT_SSER0],
			w[SCG_BIT_ASER1], w[SCG_BIT_ASER0]};
	endfunction

endpackage

// ### hdl/scg_gate_sel.sv
// module: picks the active gate word from power mode and auto select
`timescale 1ns/1ps
module scg_gate_sel
	import scg_pkg::*;
(
	// gate words
	input  wire logic [31:0] run_word,
	input  wire logic [31:0] sleep_word,
	input  wire logic [31:0] deep_word,
	// selection
	input  wire scg_mode_t   mode,
	input  wire logic        auto_sel,
	// result
	output logic [SCG_NUM_UNITS-1:0] unit_en
);

	logic [31:0] word;

	always_comb begin
		word = run_word;
		if (auto_sel) begin
			unique case (mode)
				SCG_MODE_RUN:   word = run_word;
				SCG_MODE_SLEEP: word = sleep_word;
				SCG_MODE_DEEP:  word = deep_word;
				default:        word = run_word;
			endcase
		end
		// without auto select, sleep keeps the run enables
		unit_en = scg_units(word);
	end

endmodule

// ### hdl/scg_fault_chk.sv
// module: flags accesses aimed at a unit whose clock is gated off
`timescale 1ns/1ps
module scg_fault_chk
	import scg_pkg::*;
(
	// unit access
	input  wire scg_unit_req_t           ureq,
	input  wire logic [SCG_NUM_UNITS-1:0] unit_en,
	// verdict
	output logic                         fault
);

	// any selected unit whose enable is low faults the access
	always_comb begin
		fault = ureq.en && |(ureq.sel & ~unit_en);
	end

endmodule

// ### hdl/scg_sleep_gate.sv
// module: sleep mode clock gate register block with apb slave
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ps
module scg_sleep_gate
	import scg_pkg::*;
(
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [11:0]              paddr,
	input  wire logic [31:0]              pwdata,
	output logic [31:0]                   prdata,
	output logic                          pready,
	output logic                          pslverr,
	// power mode from the power controller
	input  wire scg_mode_t                power_mode,
	// peripheral unit access, answered next cycle
	input  wire scg_unit_req_t            unit_req,
	output logic                          unit_fault,
	// per-unit clock enables
	output logic [SCG_NUM_UNITS-1:0]      unit_clk_en,
	// interrupt
	output logic                          irq
);

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	logic [31:0]              run_r, run_nxt;
	logic [31:0]              sleep_r, sleep_nxt;
	logic [31:0]              deep_r, deep_nxt;
	logic [31:0]              cfg_r, cfg_nxt;
	logic [1:0]               stat_r, stat_nxt;
	logic [1:0]               mask_r, mask_nxt;
	logic [31:0]              rdata_r, rdata_nxt;
	logic                     ready_r, ready_nxt;
	logic                     err_r, err_nxt;
	logic                     ufault_r, ufault_nxt;
	logic [SCG_NUM_UNITS-1:0] clken_r, clken_nxt;
	logic                     irq_r, irq_nxt;

	logic [SCG_NUM_UNITS-1:0] unit_en;
	logic                     fault_now;
	scg_req_t                 req;
	logic                     wr_go;
	logic                     rd_go;
	logic                     hit;

	assign req = '{sel: psel, wr: pwrite, en: penable, addr: paddr,
		wdata: pwdata};
	// one-wait answer: the access phase ends when ready_r is seen
	assign wr_go = req.sel && req.en && req.wr && !ready_r;
	assign rd_go = req.sel && req.en && !req.wr && !ready_r;

	// ------------------------------------------------------------------
	// gate select and fault check
	// ------------------------------------------------------------------
	scg_gate_sel u_sel (
		.run_word   (run_r),
		.sleep_word (sleep_r),
		.deep_word  (deep_r),
		.mode       (power_mode),
		.auto_sel   (cfg_r[SCG_BIT_AUTO_SEL]),
		.unit_en    (unit_en)
	);

	scg_fault_chk u_chk (
		.ureq    (unit_req),
		.unit_en (clken_r),
		.fault   (fault_now)
	);

	// ------------------------------------------------------------------
	// register file and bus
	// ------------------------------------------------------------------
	always_comb begin
		run_nxt   = run_r;
		sleep_nxt = sleep_r;
		deep_nxt  = deep_r;
		cfg_nxt   = cfg_r;
		mask_nxt  = mask_r;
		stat_nxt  = stat_r;
		rdata_nxt = rdata_r;
		err_nxt   = 1'b0;
		ready_nxt = 1'b0;
		hit       = 1'b1;
		if (req.sel && req.en && !ready_r) begin
			ready_nxt = 1'b1;
		end
		if (wr_go) begin
			unique case (req.addr)
				SCG_OFF_RUN:      run_nxt   = req.wdata & SCG_GATE_MASK;
				SCG_OFF_SLEEP:    sleep_nxt = req.wdata & SCG_GATE_MASK;
				SCG_OFF_DEEP:     deep_nxt  = req.wdata & SCG_GATE_MASK;
				SCG_OFF_CONFIG:   cfg_nxt[SCG_BIT_AUTO_SEL] =
					req.wdata[SCG_BIT_AUTO_SEL];
				SCG_OFF_IRQ_MASK: mask_nxt  = req.wdata[1:0];
				SCG_OFF_IRQ_STAT: stat_nxt  = stat_r & ~req.wdata[1:0];
				SCG_OFF_PMODE:    hit       = 1'b0;
				default:          hit       = 1'b0;
			endcase
			err_nxt = !hit;
		end
		if (rd_go) begin
			unique case (req.addr)
				SCG_OFF_RUN:      rdata_nxt = run_r;
				SCG_OFF_SLEEP:    rdata_nxt = sleep_r;
				SCG_OFF_DEEP:     rdata_nxt = deep_r;
				SCG_OFF_CONFIG:   rdata_nxt = cfg_r;
				SCG_OFF_IRQ_STAT: rdata_nxt = {30'h0, stat_r};
				SCG_OFF_IRQ_MASK: rdata_nxt = {30'h0, mask_r};
				SCG_OFF_PMODE:    rdata_nxt = {30'h0, power_mode};
				default: begin
					rdata_nxt = SCG_ZERO_WORD;
					hit       = 1'b0;
				end
			endcase
			err_nxt = !hit;
		end
		// events: set wins over the write-one clear above
		if (fault_now) begin
			stat_nxt[SCG_IRQ_FAULT] = 1'b1;
		end
		if (unit_en != clken_r) begin
			stat_nxt[SCG_IRQ_CHANGE] = 1'b1;
		end
		clken_nxt  = unit_en;
		ufault_nxt = fault_now;
		irq_nxt    = |(stat_nxt & mask_nxt);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_r    <= SCG_GATE_RESET;
			sleep_r  <= SCG_GATE_RESET;
			deep_r   <= SCG_GATE_RESET;
			cfg_r    <= SCG_CONFIG_RESET;
			stat_r   <= SCG_IRQ_RESET;
			mask_r   <= SCG_IRQ_RESET;
			rdata_r  <= SCG_ZERO_WORD;
			ready_r  <= 1'b0;
			err_r    <= 1'b0;
			ufault_r <= 1'b0;
			clken_r  <= '0;
			irq_r    <= 1'b0;
		end else begin
			run_r    <= run_nxt;
			sleep_r  <= sleep_nxt;
			deep_r   <= deep_nxt;
			cfg_r    <= cfg_nxt;
			stat_r   <= stat_nxt;
			mask_r   <= mask_nxt;
			rdata_r  <= rdata_nxt;
			ready_r  <= ready_nxt;
			err_r    <= err_nxt;
			ufault_r <= ufault_nxt;
			clken_r  <= clken_nxt;
			irq_r    <= irq_nxt;
		end
	end

	assign prdata      = rdata_r;
	assign pready      = ready_r;
	assign pslverr     = err_r;
	assign unit_fault  = ufault_r;
	assign unit_clk_en = clken_r;
	assign irq         = irq_r;

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	sequence s_sleep_write;
		psel && penable && pwrite && !ready_r && paddr == SCG_OFF_SLEEP;
	endsequence

	sequence s_sleep_read;
		psel && penable && !pwrite && !ready_r && paddr == SCG_OFF_SLEEP;
	endsequence

	sequence s_apb_access;
		psel && penable && !ready_r;
	endsequence

	// the answer is a single-cycle pulse, never a held level
	sequence s_one_pulse;
		pready ##1 !pready;
	endsequence

	sequence s_sleep_active;
		cfg_r[SCG_BIT_AUTO_SEL] && power_mode == SCG_MODE_SLEEP;
	endsequence

	a_sleep_reset_zero: assert property (@(posedge pclk)
		$rose(presetn) |-> sleep_r == SCG_GATE_RESET)
		else $error("sleep gate register not zero after reset");

	a_sleep_write_store: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_sleep_write |=> sleep_r == ($past(pwdata) & SCG_GATE_MASK))
		else $error("sleep gate write not stored");

	a_reserved_zero: assert property (@(posedge pclk)
		disable iff (!presetn) (sleep_r & ~SCG_GATE_MASK) == SCG_ZERO_WORD)
		else $error("reserved sleep gate bit set");

	a_sleep_applies: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[0] && power_mode == SCG_MODE_SLEEP
		|=> unit_clk_en == scg_units($past(sleep_r)))
		else $error("sleep enables not applied");

	a_run_fallback: assert property (@(posedge pclk)
		disable iff (!presetn)
		!cfg_r[0] |=> unit_clk_en == scg_units($past(run_r)))
		else $error("run enables not used without auto select");

	a_deep_applies: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[0] && power_mode == SCG_MODE_DEEP
		|=> unit_clk_en == scg_units($past(deep_r)))
		else $error("deep enables not applied");

	a_comp_gate: assert property (@(posedge pclk)
		disable iff (!presetn)
		cfg_r[0] && power_mode == SCG_MODE_SLEEP
		|=> unit_clk_en[7] == $past(sleep_r[SCG_BIT_CMP0]))
		else $error("comparator gate wrong bit");

	a_fault_gated: assert property (@(posedge pclk)
		disable iff (!presetn)
		unit_req.en && |(unit_req.sel & ~unit_clk_en) |=> unit_fault)
		else $error("gated unit access without fault");

	a_no_fault_open: assert property (@(posedge pclk)
		disable iff (!presetn)
		unit_req.en && (unit_req.sel & ~unit_clk_en) == '0 |=> !unit_fault)
		else $error("fault on clocked unit");

	a_apb_one_wait: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_apb_access |=> s_one_pulse)
		else $error("apb answer timing wrong");

	// ------------------------------------------------------------------
	// assertions: per-unit bit mapping while asleep
	// ------------------------------------------------------------------
	a_timer_gates: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_sleep_active |=> unit_clk_en[6:4] ==
			$past(sleep_r[SCG_BIT_TMR2:SCG_BIT_TMR0]))
		else $error("timer gate bits wrong");

	a_twowire_gate: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_sleep_active |=>
			unit_clk_en[3] == $past(sleep_r[SCG_BIT_TWI0]))
		else $error("two-wire gate bit wrong");

	a_sync_gate: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_sleep_active |=>
			unit_clk_en[2] == $past(sleep_r[SCG_BIT_SSER0]))
		else $error("sync serial gate bit wrong");

	a_async_gates: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_sleep_active |=> unit_clk_en[1:0] ==
			$past(sleep_r[SCG_BIT_ASER1:SCG_BIT_ASER0]))
		else $error("async serial gate bits wrong");

	// ------------------------------------------------------------------
	// assertions: reset, reserved bits, read path and fault status
	// ------------------------------------------------------------------
	a_enables_reset: assert property (@(posedge pclk)
		$rose(presetn) |-> unit_clk_en == '0)
		else $error("unit enables not off after reset");

	a_reserved_others: assert property (@(posedge pclk)
		disable iff (!presetn)
		((run_r | deep_r) & ~SCG_GATE_MASK) == SCG_ZERO_WORD)
		else $error("reserved run or deep gate bit set");

	a_sleep_read_back: assert property (@(posedge pclk)
		disable iff (!presetn)
		s_sleep_read |=> pready && prdata == $past(sleep_r))
		else $error("sleep gate read data wrong");

	// set wins: a fault in the clearing cycle stays recorded
	a_fault_sets_stat: assert property (@(posedge pclk)
		disable iff (!presetn)
		unit_fault |-> stat_r[SCG_IRQ_FAULT])
		else $error("unit fault not recorded in status");

	a_fault_needs_en: assert property (@(posedge pclk)
		disable iff (!presetn)
		!unit_req.en |=> !unit_fault)
		else $error("unit fault without an access");

endmodule

// ### sim/scg_unit_model.sv
// partner model: peripheral bus side that issues unit accesses
`timescale 1ns/1ps
module scg_unit_model
	import scg_pkg::*;
(
	// clock
	input  wire logic                     pclk,
	// command from the bench
	input  wire logic                     go,
	input  wire logic [SCG_NUM_UNITS-1:0] sel,
	// unit access port
	output scg_unit_req_t                 ureq,
	input  wire logic                     unit_fault,
	output logic                          faulted
);
	logic en_d;

	initial begin
		ureq = '0;
		en_d = 1'b0;
		faulted = 1'b0;
	end

	always @(posedge pclk) begin
		ureq.en <= go;
		// idle select keeps toggling so a stale select is never trusted
		ureq.sel <= go ? sel : ~ureq.sel;
		en_d <= ureq.en;
		if (en_d) begin
			faulted <= unit_fault;
		end
	end
endmodule

// ### sim/scg_sleep_gate_tb_top.sv
// testbench: register and unit access checks of the sleep clock gate
`timescale 1ns/1ps
module scg_sleep_gate_tb_top
	import scg_pkg::*;
;
	logic                     pclk, presetn, psel, penable, pwrite;
	logic [11:0]              paddr;
	logic [31:0]              pwdata, prdata, v;
	logic                     pready, pslverr, unit_fault, irq, go;
	scg_mode_t                power_mode;
	scg_unit_req_t            unit_req;
	logic [SCG_NUM_UNITS-1:0] unit_clk_en, usel;
	logic                     faulted, rd_err;
	int                       fail_count, n_compared;
	int                       pos [8] = '{0, 1, 4, 12, 16, 17, 18, 24};

	scg_sleep_gate dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .power_mode(power_mode), .unit_req(unit_req),
		.unit_fault(unit_fault), .unit_clk_en(unit_clk_en), .irq(irq));

	scg_unit_model unit (.pclk(pclk), .go(go), .sel(usel),
		.ureq(unit_req), .unit_fault(unit_fault), .faulted(faulted));

	// ------------------------------------------------------------------
	// checking and bus tasks
	// ------------------------------------------------------------------
	task automatic chk_word(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chk_bit(input string what, input logic exp,
		input logic got);
		chk_word(what, {31'h0, exp}, {31'h0, got});
	endtask

	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] rdat, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no fixed wait count: the watchdog ends a hung access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic reg_wr(input logic [11:0] a, input logic [31:0] d,
		input logic e);
		logic [31:0] r;
		logic        err;
		apb(1'b1, a, d, r, err);
		chk_bit("pslverr", e, err);
	endtask

	task automatic reg_rd(input logic [11:0] a, input logic [31:0] x,
		input logic e);
		logic [31:0] r;
		logic        err;
		apb(1'b0, a, 32'h0, r, err);
		chk_word("prdata", x, r);
		chk_bit("pslverr", e, err);
	endtask

	// enables lag register and mode by one cycle, so let them settle
	task automatic chk_en(input logic [7:0] x);
		repeat (3) @(posedge pclk);
		chk_word("unit_clk_en", {24'h0, x}, {24'h0, unit_clk_en});
	endtask

	task automatic set_mode(input scg_mode_t m);
		@(posedge pclk);
		power_mode <= m;
	endtask

	task automatic unit_access(input logic [7:0] s, input logic exp);
		@(posedge pclk);
		go <= 1'b1;
		usel <= s;
		@(posedge pclk);
		go <= 1'b0;
		repeat (3) @(posedge pclk);
		chk_bit("unit_fault", exp, faulted);
	endtask

	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// clock, watchdog and test sequence
	// ------------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	initial begin
		repeat (5000) @(posedge pclk);
		fail_count++;
		stop_test();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		power_mode = SCG_MODE_RUN;
		go = 1'b0;
		usel = 8'h00;
		fail_count = 0;
		n_compared = 0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		chk_en(8'h00);
		reg_rd(SCG_OFF_SLEEP, 32'h00000000, 1'b0);
		reg_rd(SCG_OFF_DEEP, 32'h00000000, 1'b0);
		reg_wr(SCG_OFF_SLEEP, 32'hffffffff, 1'b0);
		reg_rd(SCG_OFF_SLEEP, 32'h01071013, 1'b0);
		for (int i = 0; i < 8; i++) begin
			reg_wr(SCG_OFF_RUN, 32'h1 << pos[i], 1'b0);
			chk_en(8'h1 << i);
		end
		reg_rd(SCG_OFF_IRQ_STAT, 32'h00000002, 1'b0);
		reg_wr(SCG_OFF_RUN, 32'h00000003, 1'b0);
		set_mode(SCG_MODE_SLEEP);
		chk_en(8'h03);
		apb(1'b0, SCG_OFF_SLEEP, 32'h0, v, rd_err);
		chk_word("prdata", 32'h01071013, v);
		chk_bit("pslverr", 1'b0, rd_err);
		v = (v & ~32'h01071013) | 32'h00010010;
		reg_wr(SCG_OFF_SLEEP, v, 1'b0);
		reg_wr(SCG_OFF_CONFIG, 32'h00000001, 1'b0);
		chk_en(8'h14);
		reg_wr(SCG_OFF_DEEP, 32'h01000002, 1'b0);
		set_mode(SCG_MODE_DEEP);
		chk_en(8'h82);
		set_mode(SCG_MODE_RUN);
		chk_en(8'h03);
		set_mode(SCG_MODE_SLEEP);
		chk_en(8'h14);
		reg_wr(SCG_OFF_IRQ_STAT, 32'h00000003, 1'b0);
		unit_access(8'h01, 1'b1);
		unit_access(8'h04, 1'b0);
		chk_bit("irq", 1'b0, irq);
		reg_wr(SCG_OFF_IRQ_MASK, 32'h00000001, 1'b0);
		chk_en(8'h14);
		chk_bit("irq", 1'b1, irq);
		reg_wr(SCG_OFF_IRQ_STAT, 32'h00000001, 1'b0);
		chk_en(8'h14);
		chk_bit("irq", 1'b0, irq);
		reg_rd(SCG_OFF_IRQ_STAT, 32'h00000000, 1'b0);
		reg_wr(SCG_OFF_PMODE, 32'h00000002, 1'b1);
		reg_rd(SCG_OFF_PMODE, 32'h00000001, 1'b0);
		reg_wr(12'h300, 32'hffffffff, 1'b1);
		reg_rd(12'h300, 32'h00000000, 1'b1);
		stop_test();
	end
endmodule
